/* common/msb_pkg.sv */
// Purpose: Shared constants and types for the motor supply and brake supervisor.
// Assumes: One 40 MHz clock; parameter objects are reached by index and subindex.
// Notes: Slot numbers map each parameter object entry (index and subindex) onto one storage word.
`default_nettype none

package msb_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / US_PER_S) * TICK_PERIOD_US;

    // ------------------------------------------------------------------
    // Object indices and subindices
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_OV_THR = 16'h2034;
    localparam logic [15:0] IDX_UV_THR = 16'h2035;
    localparam logic [15:0] IDX_IDLE_TIME = 16'h2036;
    localparam logic [15:0] IDX_RED_SET = 16'h2037;
    localparam logic [15:0] IDX_BRAKE_TIMING = 16'h2038;
    localparam logic [7:0] SUB_ZERO = 8'h00;
    localparam logic [7:0] BRAKE_SUB_COUNT = 8'h06;

    // ------------------------------------------------------------------
    // Storage slots and values after reset
    // ------------------------------------------------------------------
    localparam logic [3:0] SLOT_OV = 4'h0;
    localparam logic [3:0] SLOT_UV = 4'h1;
    localparam logic [3:0] SLOT_IDLE = 4'h2;
    localparam logic [3:0] SLOT_RED = 4'h3;
    localparam logic [3:0] SLOT_COUNT = 4'h4;
    localparam logic [3:0] SLOT_CLOSE = 4'h5;
    localparam logic [3:0] SLOT_PWROFF = 4'h6;
    localparam logic [3:0] SLOT_OPEN = 4'h7;
    localparam logic [3:0] SLOT_START = 4'h8;
    localparam logic [3:0] SLOT_FREQ = 4'h9;
    localparam logic [3:0] SLOT_DUTY = 4'ha;
    localparam logic [3:0] SLOT_NONE = 4'hf;
    localparam int NUM_SLOTS = 11;
    localparam logic [31:0] CFG_RESET [0:NUM_SLOTS-1] = '{
        32'h0000c20d, 32'h00002710, 32'h000003e8, 32'h0fffffce, 32'h00000006,
        32'h000003e8, 32'h000003e8, 32'h000003e8, 32'h00000000, 32'h00000000,
        32'h00000000};

    // ------------------------------------------------------------------
    // Supervision, reduction and PWM limits
    // ------------------------------------------------------------------
    localparam logic [32:0] OV_HYST_MV = 33'h0000007d0;
    localparam logic [32:0] UV_HYST_MV = 33'h0000005dc;
    localparam int SUBMODE_REDUCE_BIT = 3;
    localparam logic signed [31:0] RED_PCT_MIN = -32'sh00000064;
    localparam logic signed [31:0] RED_PCT_MAX = -32'sh00000001;
    localparam logic [31:0] PCT_FULL = 32'h00000064;
    localparam logic [38:0] PCT_DIV = 39'h0000000064;
    localparam logic [31:0] PWM_FREQ_MAX = 32'h000007d0;
    localparam logic [31:0] PWM_DUTY_MIN = 32'h00000002;
    localparam logic [31:0] PWM_DUTY_MAX = 32'h00000064;
    localparam logic [26:0] PWM_ACC_MOD = 27'(CLK_HZ);
    localparam logic [31:0] PWM_DUTY_STEP = 32'(CLK_HZ / 100);

    // ------------------------------------------------------------------
    // Brake and power sequence states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF = 6'b000001,
        ST_POWER_ON = 6'b000010,
        ST_OPENING = 6'b000100,
        ST_RUN = 6'b001000,
        ST_STOPPING = 6'b010000,
        ST_CLOSING = 6'b100000
    } msb_state_t;

endpackage

`default_nettype wire

/* src/msb_supervisor.sv */
// Purpose: Supply voltage supervision, open loop current reduction and brake sequencing.
// Assumes: Inputs are synchronous to clk; the parameter port is driven one request at a time.
// Notes: Every output is registered; parameter answers appear one cycle after the request.
//
// Behaviour
// - Supply above upper threshold raises overvoltage error and switches motor off.
// - Overvoltage error clears itself below upper threshold minus two volts.
// - Supply below lower threshold raises undervoltage error and switches motor off.
// - Undervoltage error clears itself above lower threshold plus one and a half volts.
// - Current reduction starts only after continuous standstill for the idle time.
// - Reduced current applies only while reduction enable bit is set and motor stands.
// - Setting zero or positive below rated current is the reduced rms current.
// - Setting from -1 to -100 gives rated times (setting plus 100) over 100.
// - Brake delays are in milliseconds, stored beside PWM frequency and duty.
// - After standstill, wait close brake idle time, then close the brake.
// - After closing the brake, wait shutdown delay, then switch motor current off.
// - On enable, switch current on, wait open brake delay, then open the brake.
// - After brake opens, wait start operation delay before the running state.
// - Brake PWM frequency is in hertz, 0 to 2000, generated at that rate.
// - Brake PWM duty is in percent, 0 or 2 to 100, applied to the output.
// - Brake timing entry count reads six and writes to it are refused.
// - Every commanded or reduced current is clamped to the maximum motor current.
`timescale 1ns/100ps
`default_nettype none

module msb_supervisor #(
    parameter int unsigned TickCycles = msb_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSub,
    input wire logic odWrite,
    input wire logic odRead,
    input wire logic [31:0] odWdata,
    output logic [31:0] odRdata,
    output logic odAck,
    output logic odRefuse,
    input wire logic [31:0] supplyMv,
    input wire logic standstill,
    input wire logic enableReq,
    input wire logic [31:0] motorDriveSubmodeSelect,
    input wire logic [31:0] ratedMotorCurrent,
    input wire logic [31:0] maxMotorCurrentLimit,
    input wire logic [31:0] commandCurrent,
    output logic overvoltageError,
    output logic undervoltageError,
    output logic motorPowerOn,
    output logic brakeOpen,
    output logic brakePwm,
    output logic driveRunning,
    output logic reductionActive,
    output logic [31:0] currentSetpoint
);
    import msb_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] objSlot(input logic [15:0] idx, input logic [7:0] sub);
        logic [3:0] s;
        s = SLOT_NONE;
        if (idx == IDX_BRAKE_TIMING && sub <= BRAKE_SUB_COUNT) begin
            s = 4'(SLOT_COUNT + sub[3:0]);
        end else if (sub == SUB_ZERO) begin
            unique case (idx)
                IDX_OV_THR: s = SLOT_OV;
                IDX_UV_THR: s = SLOT_UV;
                IDX_IDLE_TIME: s = SLOT_IDLE;
                IDX_RED_SET: s = SLOT_RED;
                default: s = SLOT_NONE;
            endcase
        end
        return s;
    endfunction

    function automatic logic writeOk(input logic [3:0] s, input logic [31:0] v);
        logic ok;
        ok = (s != SLOT_NONE) && (s != SLOT_COUNT);
        if (s == SLOT_FREQ && v > PWM_FREQ_MAX) begin
            ok = 1'b0;
        end
        if (s == SLOT_DUTY && v != 32'h0 && (v < PWM_DUTY_MIN || v > PWM_DUTY_MAX)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // Parameter objects
    // ------------------------------------------------------------------
    logic [31:0] cfg_q [0:NUM_SLOTS-1];
    logic [31:0] cfg_d [0:NUM_SLOTS-1];
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic refuse_q, refuse_d;
    logic [3:0] slot;

    always_comb begin
        slot = objSlot(odIndex, odSub);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        rdata_d = rdata_q;
        ack_d = 1'b0;
        refuse_d = 1'b0;
        if (odWrite) begin
            ack_d = 1'b1;
            if (writeOk(slot, odWdata)) begin
                cfg_d[slot] = odWdata;
            end else begin
                refuse_d = 1'b1;
            end
        end else if (odRead) begin
            ack_d = 1'b1;
            if (slot == SLOT_NONE) begin
                refuse_d = 1'b1;
                rdata_d = 32'h0;
            end else begin
                rdata_d = cfg_q[slot];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                cfg_q[i] <= CFG_RESET[i];
            end
            rdata_q <= 32'h0;
            ack_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            refuse_q <= refuse_d;
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    logic [31:0] tickCnt_q, tickCnt_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = (tickCnt_q == 32'(TickCycles - 1));
        tickCnt_d = tick_d ? 32'h0 : tickCnt_q + 32'h1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tickCnt_q <= tickCnt_d;
            tick_q <= tick_d;
        end
    end

    // ------------------------------------------------------------------
    // Supply supervision
    // ------------------------------------------------------------------
    logic ovErr_q, ovErr_d;
    logic uvErr_q, uvErr_d;
    logic ovSet, ovClr, uvSet, uvClr;

    always_comb begin
        ovSet = supplyMv > cfg_q[SLOT_OV];
        ovClr = ({1'b0, supplyMv} + OV_HYST_MV) < {1'b0, cfg_q[SLOT_OV]};
        uvSet = supplyMv < cfg_q[SLOT_UV];
        uvClr = {1'b0, supplyMv} > ({1'b0, cfg_q[SLOT_UV]} + UV_HYST_MV);
        ovErr_d = ovSet ? 1'b1 : (ovClr ? 1'b0 : ovErr_q);
        uvErr_d = uvSet ? 1'b1 : (uvClr ? 1'b0 : uvErr_q);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovErr_q <= 1'b0;
            uvErr_q <= 1'b0;
        end else begin
            ovErr_q <= ovErr_d;
            uvErr_q <= uvErr_d;
        end
    end

    // ------------------------------------------------------------------
    // Brake and power sequence
    // ------------------------------------------------------------------
    msb_state_t state_q, state_d;
    logic [31:0] stMs_q, stMs_d;
    logic power_q, power_d;
    logic brake_q, brake_d;
    logic running_q, running_d;
    logic fault;

    always_comb begin
        fault = ovErr_q | uvErr_q;
        state_d = state_q;
        stMs_d = (tick_q && stMs_q != 32'hffffffff) ? stMs_q + 32'h1 : stMs_q;
        unique case (state_q)
            ST_OFF: begin
                if (enableReq && !fault) begin
                    state_d = ST_POWER_ON;
                end
            end
            ST_POWER_ON: begin
                if (fault || !enableReq) begin
                    state_d = ST_OFF;
                end else if (stMs_q >= cfg_q[SLOT_OPEN]) begin
                    state_d = ST_OPENING;
                end
            end
            ST_OPENING: begin
                if (fault) begin
                    state_d = ST_OFF;
                end else if (!enableReq) begin
                    state_d = ST_STOPPING;
                end else if (stMs_q >= cfg_q[SLOT_START]) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault) begin
                    state_d = ST_OFF;
                end else if (!enableReq) begin
                    state_d = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                if (fault) begin
                    state_d = ST_OFF;
                end else if (enableReq) begin
                    state_d = ST_RUN;
                end else if (!standstill) begin
                    stMs_d = 32'h0;
                end else if (stMs_q >= cfg_q[SLOT_CLOSE]) begin
                    state_d = ST_CLOSING;
                end
            end
            ST_CLOSING: begin
                if (fault || stMs_q >= cfg_q[SLOT_PWROFF]) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (state_d != state_q) begin
            stMs_d = 32'h0;
        end
        power_d = (state_d != ST_OFF);
        brake_d = (state_d == ST_OPENING) || (state_d == ST_RUN) || (state_d == ST_STOPPING);
        running_d = (state_d == ST_RUN);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            stMs_q <= 32'h0;
            power_q <= 1'b0;
            brake_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stMs_q <= stMs_d;
            power_q <= power_d;
            brake_q <= brake_d;
            running_q <= running_d;
        end
    end

    // ------------------------------------------------------------------
    // Current reduction and clamp
    // ------------------------------------------------------------------
    logic [31:0] idleMs_q, idleMs_d;
    logic reduce_q, reduce_d;
    logic [31:0] setpoint_q, setpoint_d;
    logic redAbs, redPct;
    logic [6:0] pctVal;
    logic [38:0] pctProd;
    logic [31:0] pctCurrent, target;

    always_comb begin
        if (!standstill) begin
            idleMs_d = 32'h0;
        end else if (tick_q && idleMs_q != 32'hffffffff) begin
            idleMs_d = idleMs_q + 32'h1;
        end else begin
            idleMs_d = idleMs_q;
        end
        reduce_d = standstill && motorDriveSubmodeSelect[SUBMODE_REDUCE_BIT] && power_q
            && (idleMs_q >= cfg_q[SLOT_IDLE]);
        redAbs = !cfg_q[SLOT_RED][31] && (cfg_q[SLOT_RED] < ratedMotorCurrent);
        redPct = ($signed(cfg_q[SLOT_RED]) >= RED_PCT_MIN) && ($signed(cfg_q[SLOT_RED]) <= RED_PCT_MAX);
        pctVal = 7'(cfg_q[SLOT_RED] + PCT_FULL);
        pctProd = 39'(ratedMotorCurrent) * 39'(pctVal);
        pctCurrent = 32'(pctProd / PCT_DIV);
        if (!power_q) begin
            target = 32'h0;
        end else if (reduce_q && redAbs) begin
            target = cfg_q[SLOT_RED];
        end else if (reduce_q && redPct) begin
            target = pctCurrent;
        end else begin
            target = commandCurrent;
        end
        setpoint_d = (target > maxMotorCurrentLimit) ? maxMotorCurrentLimit : target;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idleMs_q <= 32'h0;
            reduce_q <= 1'b0;
            setpoint_q <= 32'h0;
        end else begin
            idleMs_q <= idleMs_d;
            reduce_q <= reduce_d;
            setpoint_q <= setpoint_d;
        end
    end

    // ------------------------------------------------------------------
    // Brake software PWM
    // ------------------------------------------------------------------
    logic [26:0] pwmAcc_q, pwmAcc_d;
    logic pwm_q, pwm_d;
    logic [26:0] pwmSum;
    logic [31:0] dutyThr;
    logic pwmSteady;

    always_comb begin
        pwmSum = pwmAcc_q + 27'(cfg_q[SLOT_FREQ][10:0]);
        pwmAcc_d = (pwmSum >= PWM_ACC_MOD) ? pwmSum - PWM_ACC_MOD : pwmSum;
        if (!brake_d) begin
            pwmAcc_d = 27'h0;
        end
        dutyThr = 32'(cfg_q[SLOT_DUTY][6:0]) * PWM_DUTY_STEP;
        pwmSteady = (cfg_q[SLOT_FREQ] == 32'h0) || (cfg_q[SLOT_DUTY] == 32'h0);
        pwm_d = brake_d && (pwmSteady || (32'(pwmAcc_q) < dutyThr));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwmAcc_q <= 27'h0;
            pwm_q <= 1'b0;
        end else begin
            pwmAcc_q <= pwmAcc_d;
            pwm_q <= pwm_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign odRdata = rdata_q;
    assign odAck = ack_q;
    assign odRefuse = refuse_q;
    assign overvoltageError = ovErr_q;
    assign undervoltageError = uvErr_q;
    assign motorPowerOn = power_q;
    assign brakeOpen = brake_q;
    assign brakePwm = pwm_q;
    assign driveRunning = running_q;
    assign reductionActive = reduce_q;
    assign currentSetpoint = setpoint_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ov_raise_off_a: assert property ((supplyMv > cfg_q[SLOT_OV]) |=> ovErr_q ##1 !power_q)
        else $error("Overvoltage did not raise the error and switch off.");
    ov_auto_clear_a: assert property ((ovErr_q && cfg_q[SLOT_OV] >= 32'h7d0 &&
        supplyMv < cfg_q[SLOT_OV] - 32'h7d0) |=> !ovErr_q)
        else $error("Overvoltage error did not clear below the hysteresis band.");
    uv_raise_off_a: assert property ((supplyMv < cfg_q[SLOT_UV]) |=> uvErr_q ##1 !power_q)
        else $error("Undervoltage did not raise the error and switch off.");
    uv_auto_clear_a: assert property ((uvErr_q && {1'b0, supplyMv} > {1'b0, cfg_q[SLOT_UV]} + 33'h5dc)
        |=> !uvErr_q)
        else $error("Undervoltage error did not clear above the hysteresis band.");
    reduce_wait_a: assert property ($rose(reduce_q) |-> $past(idleMs_q) >= $past(cfg_q[SLOT_IDLE]))
        else $error("Reduction started before the idle time.");
    reduce_gate_a: assert property ((!standstill || !motorDriveSubmodeSelect[SUBMODE_REDUCE_BIT])
        |=> !reduce_q)
        else $error("Reduction active without standstill and enable bit.");
    reduce_abs_a: assert property ((reduce_q && power_q && !cfg_q[SLOT_RED][31] &&
        cfg_q[SLOT_RED] < ratedMotorCurrent && cfg_q[SLOT_RED] <= maxMotorCurrentLimit)
        |=> setpoint_q == $past(cfg_q[SLOT_RED]))
        else $error("Absolute reduced current not applied.");
    reduce_pct_a: assert property ((reduce_q && power_q && cfg_q[SLOT_RED] == 32'hffffffc4 &&
        ratedMotorCurrent == 32'h00001068 && maxMotorCurrentLimit >= 32'h00000690)
        |=> setpoint_q == 32'h00000690)
        else $error("Percentage reduced current is wrong.");
    current_clamp_a: assert property (1'b1 |=> setpoint_q <= $past(maxMotorCurrentLimit))
        else $error("Current setpoint exceeds the maximum motor current.");
    brake_open_a: assert property ((state_q == ST_POWER_ON && enableReq && !fault &&
        stMs_q >= cfg_q[SLOT_OPEN]) |=> brake_q && power_q)
        else $error("Brake did not open after the open delay.");
    brake_before_power_a: assert property ((state_q == ST_CLOSING && !fault &&
        stMs_q < cfg_q[SLOT_PWROFF]) |=> power_q && !brake_q)
        else $error("Motor current switched off before the shutdown delay.");
    run_start_a: assert property ($rose(running_q) && $past(state_q) == ST_OPENING
        |-> $past(stMs_q) >= $past(cfg_q[SLOT_START]))
        else $error("Running state reached before the start delay.");
    count_refuse_a: assert property ((odWrite && odIndex == IDX_BRAKE_TIMING && odSub == SUB_ZERO)
        |=> odRefuse && odAck ##1 cfg_q[SLOT_COUNT] == 32'h6)
        else $error("Write to the entry count was not refused.");
    pwm_off_closed_a: assert property (!brake_q |-> !pwm_q)
        else $error("Brake PWM active while the brake is closed.");

endmodule

`default_nettype wire

/* sim/msb_master.sv */
// Purpose: Fieldbus master model that reads and writes the parameter objects.
// Assumes: One request at a time; the answer comes one cycle after it is taken.
// Notes: Each request leaves its expected answer {isRead, refused, data} in expQ.
`timescale 1ns/100ps
`default_nettype none
module msb_master (
    input wire logic clk,
    output logic [15:0] odIndex,
    output logic [7:0] odSub,
    output logic odWrite,
    output logic odRead,
    output logic [31:0] odWdata
);
    logic [33:0] expQ[$];
    initial begin
        odIndex = '0;
        odSub = '0;
        odWrite = 1'b0;
        odRead = 1'b0;
        odWdata = '0;
    end
    // Released lines show the inverse so a stale value is never mistaken for a live one.
    task automatic req(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic rf);
        @(posedge clk);
        odWrite <= w;
        odRead <= !w;
        odIndex <= idx;
        odSub <= sub;
        odWdata <= d;
        expQ.push_back({!w, rf, d});
        @(posedge clk);
        odWrite <= 1'b0;
        odRead <= 1'b0;
        odIndex <= ~idx;
        odSub <= ~sub;
        odWdata <= ~d;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the supply and brake supervisor.
// Assumes: The tick is shortened to 10 clocks, so one millisecond is 10 cycles.
// Notes: Parameter answers are matched against the master's queue at falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import msb_pkg::*;
    logic clk = 1'b0, rst = 1'b1, standstill = 1'b1, enableReq = 1'b0;
    logic odWrite, odRead, odAck, odRefuse, ovErr, uvErr, motorOn, brakeOpen, brakePwm, running, redAct;
    logic [15:0] odIndex;
    logic [7:0] odSub;
    logic [31:0] odWdata, odRdata, setpoint, supplyMv = 32'd24000, submode = '0, cmd = 32'd3000;
    logic [31:0] cfg [0:5] = '{2, 2, 3, 1, 2000, 50};
    logic [31:0] vt [0:5] = '{49678, 47677, 47676, 9999, 11500, 11501};
    logic [31:0] ve [0:5] = '{4, 4, 0, 2, 2, 0};
    logic [33:0] e;
    integer seed = 32'h2329;
    int errors = 0, total_checks = 0, n, rises;
    logic pwmPrev;
    always #12.5 clk = ~clk;
    msb_master m (.clk(clk), .odIndex(odIndex), .odSub(odSub), .odWrite(odWrite), .odRead(odRead),
        .odWdata(odWdata));
    msb_supervisor #(.TickCycles(10)) dut (.clk(clk), .rst(rst), .odIndex(odIndex), .odSub(odSub),
        .odWrite(odWrite), .odRead(odRead), .odWdata(odWdata), .odRdata(odRdata), .odAck(odAck),
        .odRefuse(odRefuse), .supplyMv(supplyMv), .standstill(standstill), .enableReq(enableReq),
        .motorDriveSubmodeSelect(submode), .ratedMotorCurrent(32'd4200), .maxMotorCurrentLimit(32'd5000),
        .commandCurrent(cmd), .overvoltageError(ovErr), .undervoltageError(uvErr), .motorPowerOn(motorOn),
        .brakeOpen(brakeOpen), .brakePwm(brakePwm), .driveRunning(running), .reductionActive(redAct),
        .currentSetpoint(setpoint));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic lvl);
        n = 0;
        while (brakeOpen !== lvl && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic results();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (odAck === 1'b1) begin
            e = m.expQ.pop_front();
            chk({31'b0, odRefuse}, {31'b0, e[32]});
            if (e[33]) chk(odRdata, e[31:0]);
        end
    end
    // The whole sequence needs about 20300 cycles; 60000 cycles means a hang.
    initial begin
        #1_500_000;
        errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) m.req(1'b0, i < 4 ? IDX_OV_THR + 16'(i) : IDX_BRAKE_TIMING,
            i < 4 ? SUB_ZERO : 8'(i - 4), CFG_RESET[i], 1'b0);
        m.req(1'b1, IDX_BRAKE_TIMING, SUB_ZERO, 32'h9, 1'b1);
        m.req(1'b0, IDX_BRAKE_TIMING, SUB_ZERO, 32'h6, 1'b0);
        m.req(1'b1, IDX_BRAKE_TIMING, 8'h05, 32'h7d1, 1'b1);
        m.req(1'b1, IDX_BRAKE_TIMING, 8'h06, 32'h1, 1'b1);
        m.req(1'b1, IDX_BRAKE_TIMING, 8'h06, 32'h65, 1'b1);
        m.req(1'b0, 16'h2039, SUB_ZERO, 32'h0, 1'b1);
        foreach (cfg[i]) m.req(1'b1, IDX_BRAKE_TIMING, 8'(i + 1), cfg[i], 1'b0);
        m.req(1'b0, IDX_BRAKE_TIMING, 8'h05, 32'h7d0, 1'b0);
        m.req(1'b1, IDX_IDLE_TIME, SUB_ZERO, 32'h2, 1'b0);
        m.req(1'b1, IDX_RED_SET, SUB_ZERO, 32'hffffffc4, 1'b0);
        enableReq <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'b0, motorOn, brakeOpen}, 32'h2);
        wb(1'b1);
        chk(32'(n >= 21 && n <= 30), 32'h1);
        chk({31'b0, running}, 32'h0);
        repeat (12) @(posedge clk);
        chk({31'b0, running}, 32'h1);
        chk(setpoint, 32'd3000);
        n = 0;
        rises = 0;
        @(negedge clk);
        pwmPrev = brakePwm;
        repeat (20000) begin
            @(negedge clk);
            n += int'(brakePwm);
            rises += int'(brakePwm && !pwmPrev);
            pwmPrev = brakePwm;
        end
        chk(32'(n), 32'd10000);
        chk(32'(rises), 32'h1);
        @(posedge clk);
        submode <= 32'h8;
        standstill <= 1'b0;
        cmd <= 32'd6000 + ($random(seed) & 32'hfff);
        repeat (3) @(posedge clk);
        chk({31'b0, redAct}, 32'h0);
        chk(setpoint, 32'd5000);
        standstill <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'b0, redAct}, 32'h0);
        repeat (25) @(posedge clk);
        chk({31'b0, redAct}, 32'h1);
        chk(setpoint, 32'd1680);
        m.req(1'b1, IDX_RED_SET, SUB_ZERO, 32'd500, 1'b0);
        repeat (3) @(posedge clk);
        chk(setpoint, 32'd500);
        standstill <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'b0, redAct}, 32'h0);
        submode <= 32'h0;
        standstill <= 1'b1;
        repeat (30) @(posedge clk);
        chk({31'b0, redAct}, 32'h0);
        enableReq <= 1'b0;
        wb(1'b0);
        chk(32'(n >= 14 && n <= 23), 32'h1);
        repeat (8) @(posedge clk);
        chk({31'b0, motorOn}, 32'h1);
        repeat (16) @(posedge clk);
        chk({31'b0, motorOn}, 32'h0);
        chk(setpoint, 32'h0);
        enableReq <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (vt[i]) begin
            supplyMv <= vt[i];
            repeat (4) @(posedge clk);
            chk({29'b0, ovErr, uvErr, motorOn & (ovErr | uvErr)}, ve[i]);
        end
        chk(32'(m.expQ.size()), 32'h0);
        results();
    end
endmodule
`default_nettype wire
